// ===== urxmf_cfg.svh
// Constants for the multidrop UART receiver
`ifndef URXMF_CFG_SVH
`define URXMF_CFG_SVH
`define URXMF_ADDR_CTRL 12'h000
`define URXMF_ADDR_CFG 12'h004
`define URXMF_ADDR_DATA 12'h008
`define URXMF_ADDR_STAT 12'h00c
`define URXMF_SPB_NORM 5'h10
`define URXMF_SPB_DBL 5'h08
`define URXMF_SF_NORM 5'h08
`define URXMF_SF_DBL 5'h04
`define URXMF_SM_NORM 5'h09
`define URXMF_SM_DBL 5'h05
`define URXMF_CSZ_NINE 3'h7
`define URXMF_DIV_RESET 16'h0000
`define URXMF_CSZ_RESET 3'h3
`define URXMF_FIFO_DEPTH 2'h2
`endif

// ===== urxmf_pkg.sv
// Types for the multidrop UART receiver
package urxmf_pkg;
    typedef enum logic [2:0] {
        URXMF_IDLE = 3'h0,
        URXMF_START = 3'h1,
        URXMF_DATA = 3'h3,
        URXMF_PAR = 3'h2,
        URXMF_STOP = 3'h6
    } urxmf_state_t;
endpackage : urxmf_pkg

// ===== urxmf_top.sv
// Multidrop UART receiver with address filter and APB registers
`timescale 1ns/1ps
`include "urxmf_cfg.svh"
// What this block does
// - Sixteen samples per bit normally, eight in double speed.
// - First vote sample is 8 normally, 4 in double speed.
// - Middle vote sample is 9 normally, 5 in double speed.
// - Data plus parity bits range from 5 to 10.
// - Address filter works only in standard mode, not extended mode.
// - With filter on in standard mode, non-address frames are dropped before the buffer.
// - Transmitter ignores the filter enable.
// - For 5 to 8 data bits, first stop bit marks frame type.
// - For nine data bits, the ninth bit marks frame type.
// - Type bit one means address, zero means data.
// - Accepted address frame is stored and sets receive complete.
// - With filter off all data frames are accepted.
// - One character size setting is shared by receive and transmit.
// - Start bit with two of three centre samples high is noise.
// - Double speed cuts the samples per bit from 16 to 8; the divisor is unchanged.
module urxmf_top #(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic [2:0] char_size_out
);
    // ==========================================
    // Register bus
    logic rx_enable_reg;
    logic double_speed_sel_reg;
    logic addr_filter_enable_reg;
    logic extended_serial_mode_reg;
    logic parity_en_reg;
    logic parity_odd_reg;
    logic [2:0] char_size_sel_reg;
    logic [DIV_W-1:0] baud_divisor_reg;
    logic wr_en;
    logic rd_en;
    logic data_rd;
    logic pslverr_next;
    logic [1:0] fifo_cnt_reg;
    logic [11:0] fifo_mem [0:1];
    logic [11:0] head;
    // Flags read as zero once the buffer is empty
    logic rx_nonempty;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign data_rd = rd_en && (paddr == `URXMF_ADDR_DATA);
    assign pready = 1'b1;
    assign pslverr_next = !(paddr == `URXMF_ADDR_CTRL || paddr == `URXMF_ADDR_CFG ||
        paddr == `URXMF_ADDR_DATA || paddr == `URXMF_ADDR_STAT);
    assign pslverr = psel && penable && pslverr_next;
    assign head = fifo_mem[0];
    assign rx_nonempty = (fifo_cnt_reg != 2'h0);
    assign char_size_out = char_size_sel_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_enable_reg <= 1'b0;
            double_speed_sel_reg <= 1'b0;
            addr_filter_enable_reg <= 1'b0;
            extended_serial_mode_reg <= 1'b0;
            parity_en_reg <= 1'b0;
            parity_odd_reg <= 1'b0;
        end else if (wr_en && paddr == `URXMF_ADDR_CTRL) begin
            rx_enable_reg <= pwdata[0];
            double_speed_sel_reg <= pwdata[1];
            addr_filter_enable_reg <= pwdata[2];
            extended_serial_mode_reg <= pwdata[3];
            parity_en_reg <= pwdata[4];
            parity_odd_reg <= pwdata[5];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            char_size_sel_reg <= `URXMF_CSZ_RESET;
            baud_divisor_reg <= DIV_W'(`URXMF_DIV_RESET);
        end else if (wr_en && paddr == `URXMF_ADDR_CFG) begin
            char_size_sel_reg <= pwdata[2:0];
            baud_divisor_reg <= pwdata[16 +: DIV_W];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            `URXMF_ADDR_CTRL: prdata[5:0] = {parity_odd_reg, parity_en_reg,
                extended_serial_mode_reg, addr_filter_enable_reg,
                double_speed_sel_reg, rx_enable_reg};
            `URXMF_ADDR_CFG: prdata = {16'(baud_divisor_reg), 13'h0000, char_size_sel_reg};
            // Ninth bit sits beside the byte; one read returns both
            `URXMF_ADDR_DATA: prdata[8:0] = (fifo_cnt_reg != 2'h0) ? head[8:0] : 9'h000;
            `URXMF_ADDR_STAT: prdata[4:0] = {rx_nonempty, head[11:9] & {3{rx_nonempty}}, 1'b0};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // Oversampling tick and input sync
    logic [DIV_W-1:0] div_cnt_reg;
    logic tick;
    logic [2:0] rx_sync_reg;
    logic rx_level_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt_reg <= '0;
        end else if (div_cnt_reg == '0) begin
            div_cnt_reg <= baud_divisor_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg - DIV_W'(1);
        end
    end
    assign tick = (div_cnt_reg == '0);

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_sync_reg <= 3'h7;
            rx_level_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rxd};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_level_reg <= rx_sync_reg[2];
            end
        end
    end

    // ==========================================
    // Receive state machine
    function automatic logic [3:0] urxmf_data_bits(input logic [2:0] csz);
        urxmf_data_bits = (csz == `URXMF_CSZ_NINE) ? 4'h9 : 4'(5 + csz[1:0]);
    endfunction

    function automatic logic urxmf_vote(input logic [2:0] s);
        urxmf_vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    urxmf_pkg::urxmf_state_t state_reg;
    logic [4:0] samp_reg;
    logic [3:0] bit_reg;
    logic [2:0] vote_reg;
    logic [8:0] shift_reg;
    logic par_reg;
    logic [4:0] spb;
    logic [4:0] sf;
    logic [4:0] sm;
    logic bit_val;
    logic bit_end;
    logic frame_done;
    logic frame_type;
    logic stop_val;
    logic keep_frame;
    logic [3:0] nbits;
    assign spb = double_speed_sel_reg ? `URXMF_SPB_DBL : `URXMF_SPB_NORM;
    assign sf = double_speed_sel_reg ? `URXMF_SF_DBL : `URXMF_SF_NORM;
    assign sm = double_speed_sel_reg ? `URXMF_SM_DBL : `URXMF_SM_NORM;
    assign nbits = urxmf_data_bits(char_size_sel_reg);
    assign bit_val = urxmf_vote(vote_reg);
    assign bit_end = tick && (samp_reg == spb);
    assign stop_val = bit_val;
    // Stop bit is judged once its third vote sample is in
    assign frame_done = (state_reg == urxmf_pkg::URXMF_STOP) && tick && (samp_reg == sm + 5'h02);
    // Type bit: ninth data bit in nine-bit mode, else first stop bit
    assign frame_type = (char_size_sel_reg == `URXMF_CSZ_NINE) ? shift_reg[8]
        : stop_val;
    assign keep_frame = !addr_filter_enable_reg || extended_serial_mode_reg || frame_type;

    always_ff @(posedge clk) begin
        if (reset) begin
            vote_reg <= 3'h7;
        end else if (tick && samp_reg >= sf && samp_reg <= sm + 5'h01) begin
            vote_reg <= {vote_reg[1:0], rx_level_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !rx_enable_reg) begin
            state_reg <= urxmf_pkg::URXMF_IDLE;
            samp_reg <= 5'h00;
        end else if (tick) begin
            samp_reg <= (samp_reg == spb) ? 5'h01 : samp_reg + 5'h01;
            case (state_reg)
                urxmf_pkg::URXMF_IDLE: begin
                    samp_reg <= 5'h01;
                    if (!rx_level_reg) begin
                        state_reg <= urxmf_pkg::URXMF_START;
                        samp_reg <= 5'h02;
                    end
                end
                urxmf_pkg::URXMF_START: begin
                    // Early check lets a noise glitch release the line quickly
                    if (samp_reg == sm + 5'h02 && bit_val) begin
                        state_reg <= urxmf_pkg::URXMF_IDLE;
                    end else if (bit_end) begin
                        state_reg <= urxmf_pkg::URXMF_DATA;
                    end
                end
                urxmf_pkg::URXMF_DATA: begin
                    if (bit_end && bit_reg == nbits - 4'h1) begin
                        state_reg <= parity_en_reg ? urxmf_pkg::URXMF_PAR
                            : urxmf_pkg::URXMF_STOP;
                    end
                end
                urxmf_pkg::URXMF_PAR: begin
                    if (bit_end) begin
                        state_reg <= urxmf_pkg::URXMF_STOP;
                    end
                end
                urxmf_pkg::URXMF_STOP: begin
                    // Only the first stop bit is used; next start may follow
                    if (frame_done) begin
                        state_reg <= urxmf_pkg::URXMF_IDLE;
                    end
                end
                default: state_reg <= urxmf_pkg::URXMF_IDLE;
            endcase
        end
    end

    // ==========================================
    // Bit counter, shifter and parity
    always_ff @(posedge clk) begin
        if (reset || !rx_enable_reg) begin
            bit_reg <= 4'h0;
            shift_reg <= 9'h000;
            par_reg <= 1'b0;
        end else if (bit_end) begin
            case (state_reg)
                urxmf_pkg::URXMF_START: begin
                    bit_reg <= 4'h0;
                    par_reg <= 1'b0;
                end
                urxmf_pkg::URXMF_DATA: begin
                    shift_reg <= {bit_val, shift_reg[8:1]};
                    par_reg <= par_reg ^ bit_val;
                    bit_reg <= bit_reg + 4'h1;
                end
                urxmf_pkg::URXMF_PAR: begin
                    par_reg <= par_reg ^ bit_val ^ parity_odd_reg;
                end
                default: begin
                    bit_reg <= bit_reg;
                end
            endcase
        end
    end

    // ==========================================
    // Two-entry receive buffer
    logic [8:0] aligned;
    logic [11:0] new_entry;
    logic push;
    logic pop;
    logic overrun;
    assign aligned = shift_reg >> (4'h9 - nbits);
    assign new_entry = {!stop_val, 1'b0, par_reg & parity_en_reg, aligned};
    // A read in the same cycle frees a slot, so the frame still lands
    assign push = frame_done && keep_frame && (fifo_cnt_reg != `URXMF_FIFO_DEPTH || pop);
    assign overrun = frame_done && keep_frame && fifo_cnt_reg == `URXMF_FIFO_DEPTH && !pop;
    assign pop = data_rd && fifo_cnt_reg != 2'h0;

    always_ff @(posedge clk) begin
        if (reset || !rx_enable_reg) begin
            fifo_cnt_reg <= 2'h0;
            fifo_mem[0] <= 12'h000;
            fifo_mem[1] <= 12'h000;
        end else begin
            // Entry: {frame error, overrun, parity error, ninth bit, byte}
            if (pop) begin
                fifo_mem[0] <= fifo_mem[1];
                fifo_mem[1][10] <= 1'b0;
            end
            if (push) begin
                if (fifo_cnt_reg == 2'h0 || (pop && fifo_cnt_reg == 2'h1)) begin
                    fifo_mem[0] <= new_entry;
                end else begin
                    fifo_mem[1] <= new_entry;
                end
            end else if (overrun && !pop) begin
                fifo_mem[1][10] <= 1'b1;
            end
            fifo_cnt_reg <= fifo_cnt_reg + 2'(push) - 2'(pop);
        end
    end
endmodule : urxmf_top

// ===== urxmf_properties.sv
// Port checker for the multidrop UART receiver
`timescale 1ns/1ps
`include "urxmf_cfg.svh"
module urxmf_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic [2:0] char_size_out
);
    // ========================================
    // Helpers
    logic acc;
    logic mapped;
    logic cfg_wr;
    logic [5:0] ctrl_reg;
    assign acc = psel && penable;
    assign mapped = paddr inside {`URXMF_ADDR_CTRL, `URXMF_ADDR_CFG, `URXMF_ADDR_DATA,
        `URXMF_ADDR_STAT};
    assign cfg_wr = acc && pwrite && paddr == `URXMF_ADDR_CFG;
    // Shadow of the control bits, to judge readback
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= 6'h00;
        end else if (acc && pwrite && paddr == `URXMF_ADDR_CTRL) begin
            ctrl_reg <= pwdata[5:0];
        end
    end
    // ========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ready_always_a: assert property (pready) else $error("pready low");
    err_unmapped_a: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
    err_quiet_a: assert property (!(acc && !mapped) |-> !pslverr) else $error("stray error");
    size_write_a: assert property (cfg_wr |=> char_size_out == $past(pwdata[2:0]))
        else $error("size not taken");
    size_hold_a: assert property (!cfg_wr |=> $stable(char_size_out))
        else $error("size moved");
    size_reset_a: assert property ($fell(reset) |-> char_size_out == `URXMF_CSZ_RESET)
        else $error("size reset value");
    ctrl_read_a: assert property (acc && !pwrite && paddr == `URXMF_ADDR_CTRL
        |-> prdata[5:0] == ctrl_reg) else $error("control readback");
    cfg_read_a: assert property (acc && !pwrite && paddr == `URXMF_ADDR_CFG
        |-> prdata[2:0] == char_size_out) else $error("size readback");
    data_width_a: assert property (acc && !pwrite && paddr == `URXMF_ADDR_DATA
        |-> prdata[31:9] == 23'h0) else $error("data upper bits");
    cover property (acc && !mapped);
    cover property (acc && !pwrite && paddr == `URXMF_ADDR_DATA && prdata[8]);
    cover property ($fell(rxd));
endmodule : urxmf_properties
bind urxmf_top urxmf_properties u_props (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .char_size_out(char_size_out));

// ===== urxmf_uart_master.sv
// Serial master model driving the receiver line
`timescale 1ns/1ps
module urxmf_uart_master (
    input wire logic clk,
    output logic txd
);
    // ========================================
    // Line idles high, as a pulled-up bus does
    initial txd = 1'b1;
    task automatic put_bit(input logic b, input int cycles);
        @(posedge clk);
        txd <= b;
        repeat (cycles - 1) @(posedge clk);
    endtask : put_bit
    // Start, data LSB first, type bit, closing stop bit
    task automatic send(input logic [7:0] d, input int nbits, input logic addr, input int per);
        put_bit(1'b0, per);
        for (int i = 0; i < nbits; i++) put_bit(d[i], per);
        put_bit(addr, per);
        put_bit(1'b1, per);
    endtask : send
endmodule : urxmf_uart_master

// ===== urxmf_top_tb.sv
// Self-checking testbench for the multidrop UART receiver
`timescale 1ns/1ps
`include "urxmf_cfg.svh"
module urxmf_top_tb;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, rxd, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] char_size_out;
    int mismatches = 0;
    int n_compared = 0;
    urxmf_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .char_size_out(char_size_out));
    urxmf_uart_master u_master (.clk(clk), .txd(rxd));
    // ========================================
    // Tasks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // ========================================
    // Clock, watchdog, tests
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude;
    end
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(0, `URXMF_ADDR_CFG, 0); check(rd, 32'h00000003);
        apb(0, `URXMF_ADDR_STAT, 0); check(rd, 32'h0);
        apb(0, 12'h010, 0); check({31'h0, err}, 32'h1);
        // Divisor 1: a sample tick every 2 clocks, so 32 clocks a bit
        apb(1, `URXMF_ADDR_CFG, 32'h00010007);
        // The size register settles after the write edge
        @(posedge clk);
        check({29'h0, char_size_out}, 32'h7);
        apb(1, `URXMF_ADDR_CTRL, 32'h5);
        u_master.send(8'h3c, 8, 1'b0, 32);
        apb(0, `URXMF_ADDR_STAT, 0); check(rd, 32'h0);
        u_master.send(8'ha5, 8, 1'b1, 32);
        apb(0, `URXMF_ADDR_STAT, 0); check(rd, 32'h10);
        apb(0, `URXMF_ADDR_DATA, 0); check(rd, 32'h1a5);
        apb(1, `URXMF_ADDR_CTRL, 32'h1);
        u_master.send(8'h3c, 8, 1'b0, 32);
        apb(0, `URXMF_ADDR_DATA, 0); check(rd, 32'h03c);
        apb(1, `URXMF_ADDR_CTRL, 32'hd);
        u_master.send(8'h69, 8, 1'b0, 32);
        apb(0, `URXMF_ADDR_DATA, 0); check(rd, 32'h069);
        // Low pulse of 4 ticks ends before the vote samples
        u_master.put_bit(1'b0, 8);
        u_master.put_bit(1'b1, 64);
        apb(0, `URXMF_ADDR_STAT, 0); check(rd, 32'h0);
        // A frame right after the glitch must arrive whole
        u_master.send(8'h96, 8, 1'b0, 32);
        apb(0, `URXMF_ADDR_DATA, 0); check(rd, 32'h096);
        // Double speed, 8 bits: a bit is 16 clocks, frames back to back
        apb(1, `URXMF_ADDR_CFG, 32'h00010003);
        apb(1, `URXMF_ADDR_CTRL, 32'h7);
        u_master.send(8'hc3, 8, 1'b0, 16);
        u_master.send(8'h5a, 8, 1'b1, 16);
        apb(0, `URXMF_ADDR_STAT, 0); check(rd, 32'h10);
        apb(0, `URXMF_ADDR_DATA, 0); check(rd & 32'hff, 32'h5a);
        apb(1, `URXMF_ADDR_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1, `URXMF_ADDR_CFG, {16'h0001, 13'h0, i[2:0]});
            u_master.send(8'hd6, 5 + i, 1'b1, 32);
            apb(0, `URXMF_ADDR_DATA, 0); check(rd & 32'hff, 32'hd6 & (32'hff >> (3 - i)));
        end
        conclude;
    end
endmodule : urxmf_top_tb
